// ===== psr_reset_ctrl.sv
// Software reset and deep-sleep clock gating control, APB slave.
// Assumes APB3 master on pclk; capability words come in as parameters.
`include "psr_map.svh"

module psr_reset_ctrl #(
	parameter logic [31:0] CAP1  = `PSR_CAP1_DEFAULT,
	parameter logic [31:0] CAP2  = `PSR_CAP2_DEFAULT,
	parameter logic [31:0] CAP4  = `PSR_CAP4_DEFAULT,
	parameter int          PORTS = 7
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             deep_sleep,
	input  wire logic [PORTS-1:0] run_gate,
	input  wire logic [PORTS-1:0] unit_sel,
	input  wire logic             unit_access,
	output logic                  unit_fault,
	output logic      [PORTS-1:0] port_clk_en,
	output logic                  watchdog_reset,
	output logic                  comparator0_reset,
	output logic                  comparator1_reset,
	output logic                  gp_timer_a_reset,
	output logic                  gp_timer_b_reset,
	output logic                  gp_timer_c_reset,
	output logic                  sync_serial_reset,
	output logic                  async_serial_reset,
	output logic                  ether_phy_reset,
	output logic                  ether_mac_reset,
	output logic      [PORTS-1:0] port_reset
);

	psr_pkg::psr_regs_t state_reg;
	psr_pkg::psr_regs_t state_next;
	logic [31:0]        rdata_reg;
	logic [31:0]        rdata_next;
	logic               err_reg;
	logic               err_next;
	logic               wr_ok;
	logic               access;
	logic               mapped;
	logic [31:0]        src0_new;
	logic [31:0]        src1_new;
	logic [31:0]        src2_new;
	logic [31:0]        gate_new;
	logic [31:0]        cfg_new;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		return a == o;
	endfunction

	assign access = psel && !penable;

	always_comb begin
		mapped = hit(paddr, `PSR_OFF_SRC0) || hit(paddr, `PSR_OFF_SRC1)
			|| hit(paddr, `PSR_OFF_SRC2) || hit(paddr, `PSR_OFF_DSGATE)
			|| hit(paddr, `PSR_OFF_CAP1) || hit(paddr, `PSR_OFF_CAP2)
			|| hit(paddr, `PSR_OFF_CAP4) || hit(paddr, `PSR_OFF_CLKCFG)
			|| hit(paddr, `PSR_OFF_STATUS);
		wr_ok = access && pwrite;
	end

	psr_write_filter u_src0 (
		.old_value (state_reg.src0),
		.wdata     (pwdata),
		.impl_mask (`PSR_SRC0_IMPL),
		.cap_mask  (CAP1),
		.wr_en     (wr_ok && hit(paddr, `PSR_OFF_SRC0)),
		.new_value (src0_new)
	);

	psr_write_filter u_src1 (
		.old_value (state_reg.src1),
		.wdata     (pwdata),
		.impl_mask (`PSR_SRC1_IMPL),
		.cap_mask  (CAP2),
		.wr_en     (wr_ok && hit(paddr, `PSR_OFF_SRC1)),
		.new_value (src1_new)
	);

	psr_write_filter u_src2 (
		.old_value (state_reg.src2),
		.wdata     (pwdata),
		.impl_mask (`PSR_SRC2_IMPL),
		.cap_mask  (CAP4),
		.wr_en     (wr_ok && hit(paddr, `PSR_OFF_SRC2)),
		.new_value (src2_new)
	);

	psr_write_filter u_gate (
		.old_value (state_reg.dsgate),
		.wdata     (pwdata),
		.impl_mask (`PSR_DSGATE_IMPL),
		.cap_mask  (CAP4),
		.wr_en     (wr_ok && hit(paddr, `PSR_OFF_DSGATE)),
		.new_value (gate_new)
	);

	psr_write_filter u_cfg (
		.old_value (state_reg.clkcfg),
		.wdata     (pwdata),
		.impl_mask (`PSR_CLKCFG_IMPL),
		.cap_mask  (`PSR_ALL_ONES),
		.wr_en     (wr_ok && hit(paddr, `PSR_OFF_CLKCFG)),
		.new_value (cfg_new)
	);

	psr_gate_ctrl #(
		.PORTS (PORTS)
	) u_gate_ctrl (
		.run_gate    (run_gate),
		.ds_gate     (state_reg.dsgate[PORTS-1:0]),
		.deep_sleep  (deep_sleep),
		.auto_gate   (state_reg.clkcfg[`PSR_BIT_ACG]),
		.unit_sel    (unit_sel),
		.unit_access (unit_access),
		.port_clk_en (port_clk_en),
		.unit_fault  (unit_fault)
	);

	always_comb begin
		state_next.src0   = src0_new;
		state_next.src1   = src1_new;
		state_next.src2   = src2_new;
		state_next.dsgate = gate_new;
		state_next.clkcfg = cfg_new;
		rdata_next        = rdata_reg;
		err_next          = 1'b0;
		if (access) begin
			err_next   = !mapped;
			rdata_next = `PSR_RST_ZERO;
			if (!pwrite) begin
				if (hit(paddr, `PSR_OFF_SRC0)) begin
					rdata_next = state_reg.src0;
				end else if (hit(paddr, `PSR_OFF_SRC1)) begin
					rdata_next = state_reg.src1;
				end else if (hit(paddr, `PSR_OFF_SRC2)) begin
					rdata_next = state_reg.src2;
				end else if (hit(paddr, `PSR_OFF_DSGATE)) begin
					rdata_next = state_reg.dsgate;
				end else if (hit(paddr, `PSR_OFF_CAP1)) begin
					rdata_next = CAP1;
				end else if (hit(paddr, `PSR_OFF_CAP2)) begin
					rdata_next = CAP2;
				end else if (hit(paddr, `PSR_OFF_CAP4)) begin
					rdata_next = CAP4;
				end else if (hit(paddr, `PSR_OFF_CLKCFG)) begin
					rdata_next = state_reg.clkcfg;
				end else if (hit(paddr, `PSR_OFF_STATUS)) begin
					rdata_next = {{(32-PORTS){1'b0}}, port_clk_en};
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
			rdata_reg <= `PSR_RST_ZERO;
			err_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = rdata_reg;
	assign pslverr = err_reg;

	assign watchdog_reset     = state_reg.src0[`PSR_BIT_WATCHDOG];
	assign comparator1_reset  = state_reg.src1[`PSR_BIT_COMPARATOR1_RESET_BIT];
	assign comparator0_reset  = state_reg.src1[`PSR_BIT_COMPARATOR0_RESET_BIT];
	assign gp_timer_c_reset   = state_reg.src1[`PSR_BIT_GP_TIMER_C_RESET_BIT];
	assign gp_timer_b_reset   = state_reg.src1[`PSR_BIT_GP_TIMER_B_RESET_BIT];
	assign gp_timer_a_reset   = state_reg.src1[`PSR_BIT_GP_TIMER_A_RESET_BIT];
	assign sync_serial_reset  = state_reg.src1[`PSR_BIT_SYNCSER];
	assign async_serial_reset = state_reg.src1[`PSR_BIT_ASYNCSER];
	assign ether_phy_reset    = state_reg.src2[`PSR_BIT_PHY];
	assign ether_mac_reset    = state_reg.src2[`PSR_BIT_MAC];
	assign port_reset         = state_reg.src2[PORTS-1:0];

endmodule // psr_reset_ctrl

// ===== psr_map.svh
// Register offsets, field positions and reset values for the soft reset
// and clock gating block. Included by every design file that needs them.
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH

`define PSR_OFF_SRC0        12'h040
`define PSR_OFF_SRC1        12'h044
`define PSR_OFF_SRC2        12'h048
`define PSR_OFF_DSGATE      12'h128
`define PSR_OFF_CAP1        12'h200
`define PSR_OFF_CAP2        12'h204
`define PSR_OFF_CAP4        12'h208
`define PSR_OFF_CLKCFG      12'h20C
`define PSR_OFF_STATUS      12'h210

`define PSR_RST_ZERO        32'h0000_0000
`define PSR_ALL_ONES        32'hFFFF_FFFF
`define PSR_CLKCFG_IMPL     32'h0000_0001

`define PSR_SRC0_IMPL       32'h0000_0008
`define PSR_SRC1_IMPL       32'h0307_0011
`define PSR_SRC2_IMPL       32'h5000_007F
`define PSR_DSGATE_IMPL     32'h5000_007F

`define PSR_BIT_WATCHDOG    3
`define PSR_BIT_COMPARATOR1_RESET_BIT       25
`define PSR_BIT_COMPARATOR0_RESET_BIT       24
`define PSR_BIT_GP_TIMER_C_RESET_BIT      18
`define PSR_BIT_GP_TIMER_B_RESET_BIT      17
`define PSR_BIT_GP_TIMER_A_RESET_BIT      16
`define PSR_BIT_SYNCSER     4
`define PSR_BIT_ASYNCSER    0
`define PSR_BIT_PHY         30
`define PSR_BIT_MAC         28
`define PSR_BIT_PORT_LO     0
`define PSR_BIT_PORT_HI     6
`define PSR_BIT_ACG         0

`define PSR_CAP1_DEFAULT    32'h0000_0008
`define PSR_CAP2_DEFAULT    32'h0307_0011
`define PSR_CAP4_DEFAULT    32'h5000_007F

`endif

// ===== psr_pkg.sv
// Types shared by the soft reset and clock gating block.
// Assumes psr_map.svh is compiled alongside.
package psr_pkg;

	typedef enum logic [1:0] {
		PSR_IDLE   = 2'b00,
		PSR_ACCESS = 2'b01
	} psr_phase_t;

	typedef struct packed {
		logic [31:0] src0;
		logic [31:0] src1;
		logic [31:0] src2;
		logic [31:0] dsgate;
		logic [31:0] clkcfg;
	} psr_regs_t;

endpackage

// ===== psr_write_filter.sv
// Masked register update: capability and implemented-bit filter.
// Assumes the caller presents the old value and the bus write data.
module psr_write_filter (
	input  wire logic [31:0] old_value,
	input  wire logic [31:0] wdata,
	input  wire logic [31:0] impl_mask,
	input  wire logic [31:0] cap_mask,
	input  wire logic        wr_en,
	output logic      [31:0] new_value
);

	logic [31:0] keep_mask;

	always_comb begin
		keep_mask = impl_mask & cap_mask;
		if (wr_en) begin
			new_value = (wdata & keep_mask) | (old_value & ~keep_mask & impl_mask);
		end else begin
			new_value = old_value & impl_mask;
		end
	end

endmodule // psr_write_filter

// ===== psr_gate_ctrl.sv
// Port clock enable and fault decision for gated peripherals.
// Assumes run-mode enables and the deep-sleep request come from outside.
module psr_gate_ctrl #(
	parameter int PORTS = 7
) (
	input  wire logic [PORTS-1:0] run_gate,
	input  wire logic [PORTS-1:0] ds_gate,
	input  wire logic             deep_sleep,
	input  wire logic             auto_gate,
	input  wire logic [PORTS-1:0] unit_sel,
	input  wire logic             unit_access,
	output logic      [PORTS-1:0] port_clk_en,
	output logic                  unit_fault
);

	always_comb begin
		if (deep_sleep && auto_gate) begin
			port_clk_en = ds_gate;
		end else begin
			port_clk_en = run_gate;
		end
		unit_fault = unit_access && ((unit_sel & ~port_clk_en) != '0);
	end

endmodule // psr_gate_ctrl

// ===== psr_reset_ctrl_monitor.sv
// Checker for the soft reset and gating block, bound to its top.
// Assumes zero-wait APB with writes landing at the setup edge.
module psr_monitor #(
	parameter logic [31:0] CAP2  = 32'h0307_0011,
	parameter logic [31:0] CAP4  = 32'h5000_007F,
	parameter int          PORTS = 7
) (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pwrite,
	input wire logic [11:0]      paddr,
	input wire logic [31:0]      pwdata,
	input wire logic [31:0]      prdata,
	input wire logic             deep_sleep,
	input wire logic [PORTS-1:0] run_gate,
	input wire logic [PORTS-1:0] unit_sel,
	input wire logic             unit_access,
	input wire logic             unit_fault,
	input wire logic [PORTS-1:0] port_clk_en,
	input wire logic             watchdog_reset,
	input wire logic             comparator0_reset,
	input wire logic             comparator1_reset,
	input wire logic             gp_timer_a_reset,
	input wire logic             gp_timer_b_reset,
	input wire logic             gp_timer_c_reset,
	input wire logic             sync_serial_reset,
	input wire logic             async_serial_reset,
	input wire logic             ether_phy_reset,
	input wire logic             ether_mac_reset,
	input wire logic [PORTS-1:0] port_reset
);
	logic [31:0] wd_q;
	wire         acc = psel && penable;
	wire  [31:0] m2  = wd_q & CAP2;
	wire  [31:0] m4  = wd_q & CAP4;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Last write data, seen one edge after the access
	always_ff @(posedge pclk) wd_q <= pwdata;
	property p_wdog;
		acc && pwrite && paddr == 12'h040 |=> watchdog_reset == wd_q[3];
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog bit wrong");
	property p_src1;
		acc && pwrite && paddr == 12'h044 |=> {comparator1_reset,
			comparator0_reset, gp_timer_c_reset, gp_timer_b_reset,
			gp_timer_a_reset, sync_serial_reset, async_serial_reset}
			== {m2[25:24], m2[18:16], m2[4], m2[0]};
	endproperty
	a_src1: assert property (p_src1) else $error("control 1 wrong");
	property p_src2;
		acc && pwrite && paddr == 12'h048 |=> {ether_phy_reset,
			ether_mac_reset, port_reset} == {m4[30], m4[28], m4[6:0]};
	endproperty
	a_src2: assert property (p_src2) else $error("control 2 wrong");
	property p_rst;
		$rose(presetn) |-> !watchdog_reset && !ether_mac_reset
			&& !comparator1_reset && port_reset == '0;
	endproperty
	a_rst: assert property (p_rst) else $error("not zero at reset");
	property p_rd0;
		acc && !pwrite && paddr == 12'h040
			|-> prdata == {28'h0, watchdog_reset, 3'h0};
	endproperty
	a_rd0: assert property (p_rd0) else $error("control 0 read");
	property p_resv;
		acc && !pwrite && paddr == 12'h048
			|-> (prdata & ~32'h5000_007F) == '0;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved set");
	property p_fault;
		unit_fault == (unit_access && |(unit_sel & ~port_clk_en));
	endproperty
	a_fault: assert property (p_fault) else $error("fault wrong");
	property p_run;
		!deep_sleep |-> port_clk_en == run_gate;
	endproperty
	a_run: assert property (p_run) else $error("run gating wrong");
	c_wr1: cover property (acc && pwrite && paddr == 12'h044);
	c_flt: cover property (unit_fault);
	c_ds: cover property (deep_sleep && port_clk_en != run_gate);
endmodule // psr_monitor

bind psr_reset_ctrl psr_monitor #(.CAP2(CAP2), .CAP4(CAP4), .PORTS(PORTS))
	u_mon (.*);

// ===== psr_reset_ctrl_bench.sv
// Self-checking bench for the soft reset and gating block.
// Assumes the checker file is compiled alongside and binds itself.
module psr_reset_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] C2 = 32'h0301_0011;
	localparam logic [31:0] C4 = 32'h5000_003F;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, err, deep_sleep = 0, unit_access = 0;
	logic [6:0]  run_gate = '0, unit_sel = '0, port_clk_en, port_reset;
	logic        unit_fault, watchdog_reset, comparator0_reset;
	logic        comparator1_reset, gp_timer_a_reset, gp_timer_b_reset;
	logic        gp_timer_c_reset, sync_serial_reset, async_serial_reset;
	logic        ether_phy_reset, ether_mac_reset;
	int          n_mismatch = 0, total_checks = 0, cyc = 0;
	wire  [16:0] rsts = {watchdog_reset, comparator1_reset, comparator0_reset,
		gp_timer_c_reset, gp_timer_b_reset, gp_timer_a_reset,
		sync_serial_reset, async_serial_reset, ether_phy_reset,
		ether_mac_reset, port_reset};
	psr_reset_ctrl #(.CAP2(C2), .CAP4(C4)) DUT (.*);
	initial forever #10 pclk = ~pclk;
	always @(posedge pclk) if (++cyc == 3000) begin
		n_mismatch++;
		conclude();
	end
	task automatic conclude();
		if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(logic [11:0] a, logic w, logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		apb(12'h040, 0, '0);
		chk("ctrl0 reset", rd, '0);
		apb(12'h044, 0, '0);
		chk("ctrl1 reset", rd, '0);
		chk("mapped ok", err, 0);
		chk("ready", pready, 1);
		apb(12'h204, 0, '0);
		chk("cap2", rd, C2);
		for (int i = 0; i < 3; i++) apb(12'h040 + 12'(4 * i), 1, '1);
		apb(12'h040, 0, '0);
		chk("ctrl0 ones", rd, 32'h0000_0008);
		apb(12'h044, 0, '0);
		chk("ctrl1 ones", rd, 32'h0307_0011 & C2);
		apb(12'h048, 0, '0);
		chk("ctrl2 ones", rd, 32'h5000_007F & C4);
		chk("held", rsts, 32'h0001_CFBF);
		apb(12'h048, 1, '0);
		chk("released", rsts, 32'h0001_CE00);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		chk("after reset", rsts, '0);
		apb(12'h0FC, 0, '0);
		chk("unmapped err", err, 1);
		run_gate <= 7'h55;
		deep_sleep <= 1;
		apb(12'h128, 1, 32'h0000_001F);
		chk("run gate", port_clk_en, 7'h55);
		apb(12'h20C, 1, 1);
		apb(12'h210, 0, '0);
		chk("status", rd, 32'h0000_001F);
		for (int i = 0; i < 5; i++) begin
			apb(12'h128, 1, 32'h1 << i);
			unit_sel <= 7'h1 << i;
			unit_access <= 1;
			@(posedge pclk);
			chk("ds gate", port_clk_en, 7'h1 << i);
			chk("clocked", unit_fault, 0);
			unit_sel <= 7'h2 << i;
			@(posedge pclk);
			chk("gated", unit_fault, 1);
		end
		conclude();
	end
endmodule // psr_reset_ctrl_bench
